// file: bench/pss_reader.sv
// reader model: cover-codes a clear secret with the latest challenge
module pss_reader (
  input  wire logic [15:0] random_challenge,
  input  wire logic [63:0] clear_secret_64,
  input  wire logic        wide,
  output logic [63:0]      coded
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] challenge_mask_64;
  assign challenge_mask_64 = {4{random_challenge}};
  // narrow codes use bits 31:0 only; upper half kept zero so stale bits never leak
  assign coded = wide ? clear_secret_64 ^ challenge_mask_64 :
                 {32'h0, clear_secret_64[31:0] ^ challenge_mask_64[31:0]};
  // bytes arrive lsb first and are assembled before this point
endmodule // pss_reader

// file: bench/pss_sessions_chk.sv
// port assertions of the password session block
module pss_sessions_chk
  import pss_pkg::*;
#(
  parameter logic [7:0] MEM_END = 8'h4f
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       rf_boot,
  input wire logic       challenge_request,
  input wire logic [15:0] random_challenge,
  input wire logic       req_valid,
  input wire pss_req_t   req,
  input wire pss_rsp_t   rsp,
  input wire logic [7:0] first_area_session_last_block,
  input wire logic       cfg_access,
  input wire logic       first_area_session_access,
  input wire logic       second_area_session_access,
  input wire logic       kill_grant,
  input wire logic       toggle_grant,
  input wire logic       single_area
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_ANSWER: assert property (req_valid |=> rsp.done) else $error("no answer after request");
  AST_NO_STRAY: assert property (rsp.done |-> $past(req_valid)) else $error("answer without request");
  AST_CHAL_RO: assert property (!challenge_request |=> $stable(random_challenge)) else $error("challenge moved");
  AST_ONE_SESS: assert property ($onehot0({cfg_access, first_area_session_access, second_area_session_access})) else $error("two sessions");
  AST_KILL: assert property (kill_grant |-> rsp.ok && $past(req.op) == PSS_OP_KILL &&
    $past(req.secret_selector) == 2'h0) else $error("bad kill grant");
  AST_TOGGLE: assert property (toggle_grant |-> rsp.ok && $past(req.op) == PSS_OP_TOGGLE &&
    $past(req.secret_selector) == 2'h3) else $error("bad toggle grant");
  AST_SEL2: assert property (req_valid && single_area && req.secret_selector == 2'h2 |=> !rsp.ok)
    else $error("selector 2 accepted in single area");
  AST_MODE: assert property (single_area == (first_area_session_last_block >= MEM_END)) else $error("area mode wrong");
  AST_BOOT: assert property (rf_boot && !req_valid |=> !(cfg_access || first_area_session_access || second_area_session_access))
    else $error("session kept over boot");
  AST_FAIL_CLOSE: assert property (req_valid && req.op == PSS_OP_PRESENT ##1 !rsp.ok
    |-> !(cfg_access || first_area_session_access || second_area_session_access)) else $error("failed present left session open");
endmodule // pss_sessions_chk
bind pss_sessions pss_sessions_chk #(.MEM_END(MEM_END)) u_chk (.clk(clk), .rst(rst), .rf_boot(rf_boot),
  .challenge_request(challenge_request), .random_challenge(random_challenge), .req_valid(req_valid), .req(req),
  .rsp(rsp), .first_area_session_last_block(first_area_session_last_block), .cfg_access(cfg_access), .first_area_session_access(first_area_session_access),
  .second_area_session_access(second_area_session_access), .kill_grant(kill_grant), .toggle_grant(toggle_grant), .single_area(single_area));

// file: bench/pss_sessions_tb.sv
// testbench of the password session block
module pss_sessions_tb;
  import pss_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, rf_boot, challenge_request, req_valid, wd;
  logic cfg_access, first_area_session_access, second_area_session_access, kill_grant, toggle_grant, single_area, attempts_locked;
  pss_req_t    req;
  pss_rsp_t    rsp;
  logic [15:0] random_challenge, r;
  logic [7:0]  first_area_session_last_block;
  logic [63:0] clr, coded;
  int          failures, comparisons, cycles;
  pss_sessions #(.MEM_END(8'h4f), .FAIL_LIMIT(4'h8)) uut (.clk(clk), .rst(rst), .rf_boot(rf_boot),
    .challenge_request(challenge_request), .random_challenge(random_challenge), .req_valid(req_valid),
    .req(req), .rsp(rsp), .first_area_session_last_block(first_area_session_last_block), .cfg_access(cfg_access),
    .first_area_session_access(first_area_session_access), .second_area_session_access(second_area_session_access), .kill_grant(kill_grant),
    .toggle_grant(toggle_grant), .single_area(single_area), .attempts_locked(attempts_locked));
  pss_reader u_rdr (.random_challenge(random_challenge), .clear_secret_64(clr), .wide(wd), .coded(coded));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chal;
    @(posedge clk) challenge_request <= 1'b1;
    @(posedge clk) challenge_request <= 1'b0;
    @(posedge clk);
  endtask
  // one request, answer checked in the single cycle it stands
  task automatic send(input pss_op_t op, input logic [1:0] sel, input logic [63:0] c, input logic w, input logic ok);
    clr = c;
    wd = w;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= {op, sel, coded};
    @(posedge clk);
    req_valid <= 1'b0;
    #1 chk({rsp.done, rsp.ok}, {1'b1, ok});
  endtask
  task automatic acc(input logic [2:0] e);
    chk({cfg_access, first_area_session_access, second_area_session_access}, e);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      failures++;
      results;
    end
  end
  initial
  begin
    {rst, rf_boot, challenge_request, req_valid, wd} = 5'h10;
    req = '0;
    clr = '0;
    first_area_session_last_block = 8'h10;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    send(PSS_OP_PRESENT, 2'h0, 64'h0, 1'b0, 1'b0);
    chal;
    r = random_challenge;
    send(PSS_OP_PRESENT, 2'h0, 64'h0, 1'b0, 1'b1);
    acc(3'b100);
    send(PSS_OP_UPDATE, 2'h0, 64'h1234abcd, 1'b0, 1'b1);
    send(PSS_OP_KILL, 2'h0, 64'h1234abcd, 1'b0, 1'b1);
    chk(kill_grant, 1'b1);
    send(PSS_OP_PRESENT, 2'h1, 64'h1234abcd, 1'b0, 1'b0);
    acc(3'b000);
    chk(attempts_locked, 1'b0);
    send(PSS_OP_PRESENT, 2'h0, 64'h1234abcd, 1'b0, 1'b0);
    chk(random_challenge, r);
    chal;
    send(PSS_OP_PRESENT, 2'h0, 64'h1234abcd, 1'b0, 1'b1);
    send(PSS_OP_UPDATE, 2'h1, 64'h55aa, 1'b0, 1'b0);
    send(PSS_OP_PRESENT, 2'h1, 64'h0, 1'b0, 1'b1);
    acc(3'b010);
    send(PSS_OP_UPDATE, 2'h1, 64'hcafe0001, 1'b0, 1'b1);
    send(PSS_OP_PRESENT, 2'h2, 64'h0, 1'b0, 1'b1);
    acc(3'b001);
    @(posedge clk) first_area_session_last_block <= 8'h4f;
    send(PSS_OP_PRESENT, 2'h2, 64'h0, 1'b0, 1'b0);
    chal;
    send(PSS_OP_PRESENT, 2'h1, 64'hcafe0001, 1'b1, 1'b1);
    send(PSS_OP_TOGGLE, 2'h3, 64'h0, 1'b0, 1'b1);
    chk(toggle_grant, 1'b1);
    @(posedge clk) rf_boot <= 1'b1;
    @(posedge clk) rf_boot <= 1'b0;
    @(posedge clk);
    #1 acc(3'b000);
    send(PSS_OP_PRESENT, 2'h1, 64'hcafe0001, 1'b1, 1'b0);
    results;
  end
endmodule // pss_sessions_tb

// file: rtl/pss_map.svh
// register map, field layout and constants of the password session block
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH
`define PSS_SEL_CFG      2'h0
`define PSS_SEL_FIRST_AREA_SESSION    2'h1
`define PSS_SEL_SECOND_AREA_SESSION    2'h2
`define PSS_SEL_PRIV     2'h3
`define PSS_SECRET_RESET 32'h0000_0000
`define PSS_LFSR_SEED    16'hace1
`define PSS_LFSR_TAPS    16'hb400
`define PSS_MEM_END      8'h4f
`define PSS_FAIL_LIMIT   4'h8
`endif

// file: rtl/pss_pkg.sv
// types of the password session block
package pss_pkg;
  typedef enum logic [2:0] {
    PSS_OP_PRESENT = 3'h0,
    PSS_OP_UPDATE  = 3'h1,
    PSS_OP_KILL    = 3'h2,
    PSS_OP_TOGGLE  = 3'h3,
    PSS_OP_RECOVER = 3'h4
  } pss_op_t;

  typedef enum logic [4:0] {
    PSS_SESS_NONE   = 5'b00001,
    PSS_SESS_CFG    = 5'b00010,
    PSS_SESS_FIRST_AREA_SESSION  = 5'b00100,
    PSS_SESS_SECOND_AREA_SESSION  = 5'b01000,
    PSS_SESS_PRIV   = 5'b10000
  } pss_sess_t;

  typedef struct packed {
    pss_op_t     op;
    logic [1:0]  secret_selector;
    logic [63:0] coded;
  } pss_req_t;

  typedef struct packed {
    logic done;
    logic ok;
  } pss_rsp_t;
endpackage

// file: rtl/pss_sessions.sv
// password security session manager with cover-coded password handling
// Notes on behaviour
// - read-only 16-bit challenge, refreshed on request
// - match opens session, mismatch closes it
// - session grants its area or config rights
// - four secrets by selector 0..3
// - dual area: area secrets are 32 bits
// - single area: 64-bit first_area_session, selector 2 fails
// - update only while same session is open
// - field loss or wrong value closes session
// - attempt on other selector closes current session
// - secret commands need challenge since boot
// - after wrong value, require fresh challenge
// - after success, no fresh challenge needed
// - masks replicate challenge across 32/64 bits
// - multi-byte fields travel lsb first
// - compare decoded field with selected secret
// - store decoded field into selected secret
// - config authorises kill, privacy authorises toggle
// - recovery rewrites secret after broken update
// - failed attempts limited by counter
// - last block below memory end means dual
// - first_area_session upper half aliases second_area_session secret
// - secrets unreadable, reset to zero
`include "pss_map.svh"
module pss_sessions
  import pss_pkg::*;
#(
  parameter logic [7:0] MEM_END    = `PSS_MEM_END,
  parameter logic [3:0] FAIL_LIMIT = `PSS_FAIL_LIMIT
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       rf_boot,
  input  wire logic       challenge_request,
  output logic [15:0]     random_challenge,
  input  wire logic       req_valid,
  input  wire pss_req_t   req,
  output pss_rsp_t        rsp,
  input  wire logic [7:0] first_area_session_last_block,
  output logic            cfg_access,
  output logic            first_area_session_access,
  output logic            second_area_session_access,
  output logic            kill_grant,
  output logic            toggle_grant,
  output logic            single_area,
  output logic            attempts_locked
);
  logic [15:0] lfsr;
  logic [31:0] config_secret;
  logic [31:0] first_area_session_secret;
  logic [31:0] second_area_session_secret;
  logic [31:0] privacy_secret;
  logic        challenge_valid;
  logic        need_fresh;
  logic        recover_armed;
  logic [3:0]  fail_count;
  pss_sess_t   session;
  logic [63:0] challenge_mask_64;
  logic [31:0] challenge_mask_32;
  logic [63:0] clear_secret_64;
  logic [31:0] clear_secret_32;
  logic [63:0] selected;
  logic        is_compare;
  logic        sel_bad;
  logic        allowed;
  logic        match;
  pss_sess_t   target;
  pss_sess_t   next_session;
  pss_rsp_t    next_rsp;
  logic [31:0] secret_bank [4];
  logic [3:0]  bank_write;
  logic [3:0][31:0] bank_data;
  logic        wide_sel;
  logic        sel_void;
  logic        kill_sel_bad;
  logic        toggle_sel_bad;
  logic        attempt;
  logic        store;
  logic        next_kill;
  logic        next_toggle;
  genvar       gi;

  // free-running generator; the reader only sees the value latched on request
  always_ff @(posedge clk)
  begin
    if (rst)
      lfsr <= `PSS_LFSR_SEED;
    else
      lfsr <= {1'b0, lfsr[15:1]} ^ (lfsr[0] ? `PSS_LFSR_TAPS : 16'h0000);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      random_challenge <= 16'h0000;
    else if (challenge_request)
      random_challenge <= lfsr;
  end

  assign single_area       = (first_area_session_last_block >= MEM_END);
  assign challenge_mask_32 = {2{random_challenge}};
  assign challenge_mask_64 = {4{random_challenge}};
  // coded field arrives already assembled lsb first into bit 0 upward
  assign clear_secret_64   = req.coded ^ challenge_mask_64;
  assign clear_secret_32   = req.coded[31:0] ^ challenge_mask_32;

  always_comb
  begin
    selected = 64'h0;
    target   = PSS_SESS_NONE;
    unique case (req.secret_selector)
      `PSS_SEL_CFG:
      begin
        selected = {32'h0, config_secret};
        target   = PSS_SESS_CFG;
      end
      `PSS_SEL_FIRST_AREA_SESSION:
      begin
        selected = single_area ? {second_area_session_secret, first_area_session_secret} : {32'h0, first_area_session_secret};
        target   = PSS_SESS_FIRST_AREA_SESSION;
      end
      `PSS_SEL_SECOND_AREA_SESSION:
      begin
        selected = {32'h0, second_area_session_secret};
        target   = PSS_SESS_SECOND_AREA_SESSION;
      end
      `PSS_SEL_PRIV:
      begin
        selected = {32'h0, privacy_secret};
        target   = PSS_SESS_PRIV;
      end
    endcase
  end

  assign is_compare = (req.op != PSS_OP_UPDATE) && (req.op != PSS_OP_RECOVER);

  // one 64-bit compare path serves both widths; the upper half is zero when narrow
  assign wide_sel       = single_area && (req.secret_selector == `PSS_SEL_FIRST_AREA_SESSION);
  // second_area_session has no session of its own while first_area_session spans the whole memory
  assign sel_void       = single_area && (req.secret_selector == `PSS_SEL_SECOND_AREA_SESSION);
  // kill must name the config secret, toggle the privacy secret
  assign kill_sel_bad   = (req.op == PSS_OP_KILL) && (req.secret_selector != `PSS_SEL_CFG);
  assign toggle_sel_bad = (req.op == PSS_OP_TOGGLE) && (req.secret_selector != `PSS_SEL_PRIV);
  assign sel_bad        = sel_void || kill_sel_bad || toggle_sel_bad;
  assign match          = wide_sel ? (clear_secret_64 == selected)
                                   : ({32'h0, clear_secret_32} == selected);

  always_comb
  begin
    allowed = challenge_valid && !sel_bad && !attempts_locked;
    if (is_compare && need_fresh)
      allowed = 1'b0;
    if (req.op == PSS_OP_UPDATE && session != target)
      allowed = 1'b0;
    if (req.op == PSS_OP_RECOVER && !(recover_armed && session == target))
      allowed = 1'b0;
  end

  // an attempt is a compare that passed every gate; only present attempts are counted
  assign attempt = req_valid && is_compare && allowed;
  assign store   = req_valid && !is_compare && allowed;

  always_ff @(posedge clk)
  begin
    if (rst || rf_boot)
      challenge_valid <= 1'b0;
    else if (challenge_request)
      challenge_valid <= 1'b1;
  end

  // a served challenge wins over a failure in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst || rf_boot)
      need_fresh <= 1'b0;
    else if (challenge_request)
      need_fresh <= 1'b0;
    else if (attempt)
      need_fresh <= !match;
  end

  // counter persists across boots so field cycling cannot reset the limit
  always_ff @(posedge clk)
  begin
    if (rst)
      fail_count <= 4'h0;
    else if (attempt && req.op == PSS_OP_PRESENT)
      fail_count <= match ? 4'h0 : fail_count + 4'h1;
  end
  assign attempts_locked = (fail_count >= FAIL_LIMIT);

  // any present closes the current session first, so a failed switch leaves none open
  always_comb
  begin
    next_session = session;
    if (req_valid && req.op == PSS_OP_PRESENT)
    begin
      if (allowed && match)
        next_session = target;
      else
        next_session = PSS_SESS_NONE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || rf_boot)
      session <= PSS_SESS_NONE;
    else
      session <= next_session;
  end

  // an update arms recovery until the next boot; a broken write can be redone
  always_ff @(posedge clk)
  begin
    if (rst || rf_boot)
      recover_armed <= 1'b0;
    else if (store && req.op == PSS_OP_UPDATE)
      recover_armed <= 1'b1;
  end

  // write strobes and data per secret; a wide first_area_session write also lands in second_area_session
  always_comb
  begin
    bank_write = 4'h0;
    bank_data  = {4{clear_secret_32}};
    if (store)
    begin
      unique case (req.secret_selector)
        `PSS_SEL_CFG:
          bank_write[0] = 1'b1;
        `PSS_SEL_FIRST_AREA_SESSION:
        begin
          bank_write[1] = 1'b1;
          if (wide_sel)
          begin
            bank_write[2] = 1'b1;
            bank_data[1]  = clear_secret_64[31:0];
            bank_data[2]  = clear_secret_64[63:32];
          end
        end
        `PSS_SEL_SECOND_AREA_SESSION:
          bank_write[2] = 1'b1;
        `PSS_SEL_PRIV:
          bank_write[3] = 1'b1;
      endcase
    end
  end

  // one storage word per secret; nothing here is ever routed to an output
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_secret
      always_ff @(posedge clk)
      begin
        if (rst)
          secret_bank[gi] <= `PSS_SECRET_RESET;
        else if (bank_write[gi])
          secret_bank[gi] <= bank_data[gi];
      end
    end
  endgenerate

  // the upper first_area_session half and second_area_session share one word, so a mode switch keeps the latest
  assign config_secret  = secret_bank[0];
  assign first_area_session_secret   = secret_bank[1];
  assign second_area_session_secret   = secret_bank[2];
  assign privacy_secret = secret_bank[3];

  always_comb
  begin
    next_rsp.done = req_valid;
    next_rsp.ok   = req_valid && allowed && (!is_compare || match);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rsp <= '0;
    else
      rsp <= next_rsp;
  end

  assign next_kill   = req_valid && (req.op == PSS_OP_KILL) && allowed && match;
  assign next_toggle = req_valid && (req.op == PSS_OP_TOGGLE) && allowed && match;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      kill_grant   <= 1'b0;
      toggle_grant <= 1'b0;
    end
    else
    begin
      kill_grant   <= next_kill;
      toggle_grant <= next_toggle;
    end
  end

  // privacy session grants only its own update, so it drives no access line

  assign cfg_access   = (session == PSS_SESS_CFG);
  assign first_area_session_access = (session == PSS_SESS_FIRST_AREA_SESSION);
  assign second_area_session_access = (session == PSS_SESS_SECOND_AREA_SESSION) && !single_area;
endmodule // pss_sessions
